// *** common/pcmsp_if.sv ***
// pcmsp_if: serial pcm highway between codec port and highway master
`timescale 1ns/100ps
interface pcmsp_if;
  logic mclk;
  logic tx_bit_clock;
  logic rx_bit_clock;
  logic tx_frame_sync;
  logic rx_frame_sync;
  logic rx_serial_in;
  logic tx_serial_out;
  logic tx_serial_oe;
  logic link_clock;
  logic link_sync;
  logic link_rx_data;
  logic link_tx_data;
  logic link_tx_oe;
  wire  tx_serial_pin;
  wire  link_tx_pin;

  // released pins float high through a pull-up
  assign tx_serial_pin = tx_serial_oe ? tx_serial_out : 1'b1;
  assign link_tx_pin   = link_tx_oe ? link_tx_data : 1'b1;

  modport dev (
    input  mclk, tx_bit_clock, rx_bit_clock, tx_frame_sync, rx_frame_sync, rx_serial_in,
    input  link_clock, link_sync, link_rx_data,
    output tx_serial_out, tx_serial_oe, link_tx_data, link_tx_oe
  );
  modport host (
    output mclk, tx_bit_clock, rx_bit_clock, tx_frame_sync, rx_frame_sync, rx_serial_in,
    output link_clock, link_sync, link_rx_data,
    input  tx_serial_pin, link_tx_pin
  );
endinterface

// *** common/pcmsp_pkg.sv ***
// pcmsp_pkg: shared constants and types of the pcm serial port
package pcmsp_pkg;
  // clocking and frame timing
  localparam int          SYS_CLK_KHZ  = 50000;
  localparam int          MCLK_KHZ     = 2048;
  localparam int          MCLK_HALF    = SYS_CLK_KHZ / (2 * MCLK_KHZ);
  localparam logic [4:0]  DIV_LAST     = 5'(MCLK_HALF - 1);
  localparam int          FRAME_US     = 125;
  localparam int          FRAME_BITS   = FRAME_US * SYS_CLK_KHZ / 1000 / (4 * MCLK_HALF);
  localparam logic [7:0]  LONG_FS_BITS = 8'h03;
  // word and slot layout
  localparam int          WORD_BITS    = 8;
  localparam int          FIFO_DEPTH   = 8;
  localparam logic [7:0]  IDLE_CODE    = 8'hFF;
  localparam logic [2:0]  LAST_BIT     = 3'h7;
  localparam logic [4:0]  SLOT_B1      = 5'h00;
  localparam logic [4:0]  SLOT_B2      = 5'h0A;
  // positions in the device's synchroniser vector
  localparam int          SY_TCLK      = 0;
  localparam int          SY_TFS       = 1;
  localparam int          SY_RCLK      = 2;
  localparam int          SY_RFS       = 3;
  localparam int          SY_RDAT      = 4;
  localparam int          SY_LCLK      = 5;
  localparam int          SY_LSYNC     = 6;
  localparam int          SY_LRX       = 7;

  typedef enum logic [1:0] {
    MODE_LONG  = 2'h0,
    MODE_SHORT = 2'h1,
    MODE_LINK  = 2'h2
  } pcmsp_mode_t;

  typedef enum logic [3:0] {
    TX_IDLE  = 4'h1,
    TX_ARM   = 4'h2,
    TX_SHIFT = 4'h4,
    TX_HOLD  = 4'h8
  } pcmsp_tx_st_t;

  typedef enum logic [2:0] {
    RX_IDLE  = 3'h1,
    RX_ARM   = 3'h2,
    RX_SHIFT = 3'h4
  } pcmsp_rx_st_t;
endpackage

// *** hw/pcmsp_dev.sv ***
// pcmsp_dev: codec end of the serial pcm port, with its transmit fifo
//
// Operation
// - master drives master clock at fixed rates
// - bit clocks run 64 to 4096 kHz
// - frame syncs sampled on bit clock fall; long-frame transmit instead starts once sync and bit clock are both high
// - receive data captured on bit clock fall
// - long sync held past second falling edge
// - long frame: msb after later rise
// - long frame: later bits on rising edges
// - long: release after 8th fall, sync fall
// - short sync high one fall, low before msb
// - short frame: bits launched on rising edges
// - short frame: release after 8th fall
// - link sync sampled on link clock fall
// - link receive data captured on fall
// - link transmit released on fall, slot end
// - link transmit enabled, updated on rises
// - transmit and receive share one channel
// - link accesses every 125 us
`timescale 1ns/100ps
module pcmsp_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  // clock and reset
  input  wire logic             clk_in,
  input  wire logic             arst_n_in,
  // filling side
  input  wire logic [WIDTH-1:0] in_data_in,
  input  wire logic             in_valid_in,
  output logic                  in_ready_out,
  // draining side
  output logic      [WIDTH-1:0] out_data_out,
  output logic                  out_valid_out,
  input  wire logic             out_ready_in
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0]    wr_q;
  logic [AW-1:0]    rd_q;
  logic [AW:0]      cnt_q;
  logic [AW:0]      cnt_d;
  wire              push;
  wire              pop;

  assign push          = in_valid_in & in_ready_out;
  assign pop           = out_valid_out & out_ready_in;
  assign cnt_d         = cnt_q + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
  assign out_valid_out = (cnt_q != '0);
  assign out_data_out  = mem_q[rd_q];

  always_ff @(posedge clk_in) begin
    if (push) begin
      mem_q[wr_q] <= in_data_in;
    end
  end

  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      wr_q         <= '0;
      rd_q         <= '0;
      cnt_q        <= '0;
      in_ready_out <= 1'b1;
    end else begin
      if (push) begin
        wr_q <= (wr_q == AW'(DEPTH - 1)) ? '0 : wr_q + 1'b1;
      end
      if (pop) begin
        rd_q <= (rd_q == AW'(DEPTH - 1)) ? '0 : rd_q + 1'b1;
      end
      cnt_q        <= cnt_d;
      in_ready_out <= (cnt_d < (AW + 1)'(DEPTH));
    end
  end
endmodule

////////////////////////////////////////////////////////////////////////////////

module pcmsp_dev (
  // clock and reset
  input  wire logic                      SYS_CLK_IN,
  input  wire logic                      ARST_N_IN,
  // configuration
  input  wire pcmsp_pkg::pcmsp_mode_t    MODE_IN,
  input  wire logic                      CHAN_B2_IN,
  // samples to send
  input  wire logic [7:0]                TX_DATA_IN,
  input  wire logic                      TX_VALID_IN,
  output logic                           TX_READY_OUT,
  // samples received
  output logic [7:0]                     RX_DATA_OUT,
  output logic                           RX_VALID_OUT,
  // serial highway
  pcmsp_if.dev                           LINK
);
  import pcmsp_pkg::*;

  logic [7:0]    sy1_q;
  logic [7:0]    sy2_q;
  logic [7:0]    sy3_q;
  wire  [7:0]    raw;
  wire           link_mode;
  wire           long_mode;
  wire  [4:0]    slot_start;
  wire           t_now;
  wire           t_old;
  wire           t_rise;
  wire           t_fall;
  wire           t_fs;
  wire           r_now;
  wire           r_old;
  wire           r_fall;
  wire           r_fs;
  wire           r_dat;
  wire  [7:0]    fifo_data;
  wire           fifo_valid;
  pcmsp_tx_st_t  tx_st_q;
  pcmsp_tx_st_t  tx_st_d;
  logic [2:0]    tbit_q;
  logic [2:0]    tbit_d;
  logic [4:0]    tcnt_q;
  logic [4:0]    tcnt_d;
  logic [7:0]    tword_q;
  logic [7:0]    tword_d;
  logic          tout_q;
  logic          tout_d;
  logic          toe_d;
  logic          tfs_low_q;
  logic          tfs_low_d;
  logic          pop;
  logic          ser_oe_q;
  logic          lnk_oe_q;
  pcmsp_rx_st_t  rx_st_q;
  pcmsp_rx_st_t  rx_st_d;
  logic [2:0]    rbit_q;
  logic [2:0]    rbit_d;
  logic [4:0]    rcnt_q;
  logic [4:0]    rcnt_d;
  logic [7:0]    rsh_q;
  logic [7:0]    rsh_d;
  logic          rfs_low_q;
  logic          rfs_low_d;
  logic          rdone;

  pcmsp_fifo #(.WIDTH(WORD_BITS), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clk_in        (SYS_CLK_IN),
    .arst_n_in     (ARST_N_IN),
    .in_data_in    (TX_DATA_IN),
    .in_valid_in   (TX_VALID_IN),
    .in_ready_out  (TX_READY_OUT),
    .out_data_out  (fifo_data),
    .out_valid_out (fifo_valid),
    .out_ready_in  (pop)
  );

  //////////////////////////////////////////////////////////////////////////////
  // pin synchronisers and edge finding on the system clock
  assign raw = {LINK.link_rx_data, LINK.link_sync, LINK.link_clock, LINK.rx_serial_in,
                LINK.rx_frame_sync, LINK.rx_bit_clock, LINK.tx_frame_sync, LINK.tx_bit_clock};

  always_ff @(posedge SYS_CLK_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      sy1_q <= 8'h00;
      sy2_q <= 8'h00;
      sy3_q <= 8'h00;
    end else begin
      sy1_q <= raw;
      sy2_q <= sy1_q;
      sy3_q <= sy2_q;
    end
  end

  assign link_mode  = (MODE_IN == MODE_LINK);
  assign long_mode  = (MODE_IN == MODE_LONG);
  assign slot_start = link_mode ? (CHAN_B2_IN ? SLOT_B2 : SLOT_B1) : SLOT_B1;
  assign t_now      = link_mode ? sy2_q[SY_LCLK] : sy2_q[SY_TCLK];
  assign t_old      = link_mode ? sy3_q[SY_LCLK] : sy3_q[SY_TCLK];
  assign t_rise     = t_now & ~t_old;
  assign t_fall     = ~t_now & t_old;
  assign t_fs       = link_mode ? sy2_q[SY_LSYNC] : sy2_q[SY_TFS];
  assign r_now      = link_mode ? sy2_q[SY_LCLK] : sy2_q[SY_RCLK];
  assign r_old      = link_mode ? sy3_q[SY_LCLK] : sy3_q[SY_RCLK];
  assign r_fall     = ~r_now & r_old;
  assign r_fs       = link_mode ? sy2_q[SY_LSYNC] : sy2_q[SY_RFS];
  assign r_dat      = link_mode ? sy2_q[SY_LRX] : sy2_q[SY_RDAT];

  //////////////////////////////////////////////////////////////////////////////
  // transmit engine
  always_comb begin
    tx_st_d   = tx_st_q;
    tbit_d    = tbit_q;
    tcnt_d    = tcnt_q;
    tword_d   = tword_q;
    tout_d    = tout_q;
    toe_d     = (tx_st_q == TX_SHIFT) || (tx_st_q == TX_HOLD);
    tfs_low_d = tfs_low_q | ~t_fs;
    pop       = 1'b0;
    case (tx_st_q)
      TX_IDLE: begin
        if (long_mode) begin
          if (t_fs && t_now && tfs_low_q) begin
            tword_d   = fifo_valid ? fifo_data : IDLE_CODE;
            pop       = fifo_valid;
            tout_d    = tword_d[7];
            toe_d     = 1'b1;
            tbit_d    = 3'h0;
            tfs_low_d = 1'b0;
            tx_st_d   = TX_SHIFT;
          end
        end else if (t_fall && t_fs) begin
          tcnt_d  = 5'h00;
          tx_st_d = TX_ARM;
        end
      end
      TX_ARM: begin
        if (t_rise && tcnt_q == slot_start) begin
          tword_d = fifo_valid ? fifo_data : IDLE_CODE;
          pop     = fifo_valid;
          tout_d  = tword_d[7];
          toe_d   = 1'b1;
          tbit_d  = 3'h0;
          tx_st_d = TX_SHIFT;
        end else if (t_fall) begin
          tcnt_d = t_fs ? 5'h00 : tcnt_q + 5'h01;
        end
      end
      TX_SHIFT: begin
        if (t_rise) begin
          tout_d = tword_q[LAST_BIT - tbit_q];
        end else if (t_fall) begin
          if (tbit_q == LAST_BIT) begin
            if (long_mode && t_fs) begin
              tx_st_d = TX_HOLD;
            end else begin
              toe_d   = 1'b0;
              tx_st_d = TX_IDLE;
            end
          end else begin
            tbit_d = tbit_q + 3'h1;
          end
        end
      end
      TX_HOLD: begin
        if (!t_fs) begin
          toe_d   = 1'b0;
          tx_st_d = TX_IDLE;
        end
      end
      default: begin
        toe_d   = 1'b0;
        tx_st_d = TX_IDLE;
      end
    endcase
  end

  always_ff @(posedge SYS_CLK_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      tx_st_q   <= TX_IDLE;
      tbit_q    <= 3'h0;
      tcnt_q    <= 5'h00;
      tword_q   <= 8'h00;
      tout_q    <= 1'b0;
      tfs_low_q <= 1'b0;
      ser_oe_q  <= 1'b0;
      lnk_oe_q  <= 1'b0;
    end else begin
      tx_st_q   <= tx_st_d;
      tbit_q    <= tbit_d;
      tcnt_q    <= tcnt_d;
      tword_q   <= tword_d;
      tout_q    <= tout_d;
      tfs_low_q <= tfs_low_d;
      ser_oe_q  <= toe_d & ~link_mode;
      lnk_oe_q  <= toe_d & link_mode;
    end
  end

  assign LINK.tx_serial_out = tout_q;
  assign LINK.tx_serial_oe  = ser_oe_q;
  assign LINK.link_tx_data  = tout_q;
  assign LINK.link_tx_oe    = lnk_oe_q;

  //////////////////////////////////////////////////////////////////////////////
  // receive engine
  always_comb begin
    rx_st_d   = rx_st_q;
    rbit_d    = rbit_q;
    rcnt_d    = rcnt_q;
    rsh_d     = rsh_q;
    rfs_low_d = rfs_low_q | ~r_fs;
    rdone     = 1'b0;
    case (rx_st_q)
      RX_IDLE: begin
        if (r_fall && r_fs) begin
          if (long_mode) begin
            if (rfs_low_q) begin
              rsh_d     = {rsh_q[6:0], r_dat};
              rbit_d    = 3'h1;
              rfs_low_d = 1'b0;
              rx_st_d   = RX_SHIFT;
            end
          end else begin
            rcnt_d  = 5'h00;
            rx_st_d = RX_ARM;
          end
        end
      end
      RX_ARM: begin
        if (r_fall) begin
          if (r_fs) begin
            rcnt_d = 5'h00;
          end else if (rcnt_q == slot_start) begin
            rsh_d   = {rsh_q[6:0], r_dat};
            rbit_d  = 3'h1;
            rx_st_d = RX_SHIFT;
          end else begin
            rcnt_d = rcnt_q + 5'h01;
          end
        end
      end
      RX_SHIFT: begin
        if (r_fall) begin
          rsh_d = {rsh_q[6:0], r_dat};
          if (rbit_q == LAST_BIT) begin
            rdone   = 1'b1;
            rx_st_d = RX_IDLE;
          end else begin
            rbit_d = rbit_q + 3'h1;
          end
        end
      end
      default: begin
        rx_st_d = RX_IDLE;
      end
    endcase
  end

  always_ff @(posedge SYS_CLK_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      rx_st_q      <= RX_IDLE;
      rbit_q       <= 3'h0;
      rcnt_q       <= 5'h00;
      rsh_q        <= 8'h00;
      rfs_low_q    <= 1'b0;
      RX_DATA_OUT  <= 8'h00;
      RX_VALID_OUT <= 1'b0;
    end else begin
      rx_st_q      <= rx_st_d;
      rbit_q       <= rbit_d;
      rcnt_q       <= rcnt_d;
      rsh_q        <= rsh_d;
      rfs_low_q    <= rfs_low_d;
      RX_VALID_OUT <= rdone;
      if (rdone) begin
        RX_DATA_OUT <= rsh_d;
      end
    end
  end
endmodule

// *** hw/pcmsp_host.sv ***
// pcmsp_host: highway master end, makes clocks and syncs of the serial port
`timescale 1ns/100ps
module pcmsp_host #(
  parameter int FRAME_LEN = pcmsp_pkg::FRAME_BITS
) (
  // clock and reset
  input  wire logic                      SYS_CLK_IN,
  input  wire logic                      ARST_N_IN,
  // configuration
  input  wire pcmsp_pkg::pcmsp_mode_t    MODE_IN,
  input  wire logic                      CHAN_B2_IN,
  // sample to send, one per frame
  input  wire logic [7:0]                TX_DATA_IN,
  input  wire logic                      TX_VALID_IN,
  output logic                           TX_READY_OUT,
  // sample received, one per frame
  output logic [7:0]                     RX_DATA_OUT,
  output logic                           RX_VALID_OUT,
  // serial highway
  pcmsp_if.host                          LINK
);
  import pcmsp_pkg::*;

  localparam logic [7:0] LAST_POS = 8'(FRAME_LEN - 1);

  logic [4:0]  div_q;
  logic        mclk_q;
  logic        phase_q;
  logic        bclk_q;
  logic [7:0]  pos_q;
  logic        fs_q;
  logic        dat_q;
  logic [7:0]  word_q;
  logic [7:0]  hold_q;
  logic        full_q;
  logic [7:0]  rsh_q;
  logic [1:0]  pin1_q;
  logic [1:0]  pin2_q;
  wire         tick;
  wire         b_rise;
  wire         b_fall;
  wire  [7:0]  pos_nx;
  wire  [7:0]  start;
  wire  [7:0]  tx_idx;
  wire  [7:0]  rx_idx;
  wire         fs_nx;
  wire         take;
  wire         load;
  wire         pin_now;

  //////////////////////////////////////////////////////////////////////////////
  // clock divider: master clock, bit clock at half its rate
  assign tick   = (div_q == DIV_LAST);
  assign b_rise = tick & phase_q & ~bclk_q;
  assign b_fall = tick & phase_q & bclk_q;
  assign pos_nx = (pos_q == LAST_POS) ? 8'h00 : pos_q + 8'h01;
  assign start  = {3'h0, (MODE_IN == MODE_LINK && CHAN_B2_IN) ? SLOT_B2 : SLOT_B1};
  assign tx_idx = pos_nx - start;
  assign rx_idx = pos_q - start;
  assign fs_nx  = (MODE_IN == MODE_LONG) ? (pos_nx < LONG_FS_BITS) : (pos_nx == LAST_POS);
  assign load   = b_rise & (pos_nx == start);
  assign take   = TX_VALID_IN & TX_READY_OUT;
  assign pin_now = (MODE_IN == MODE_LINK) ? pin2_q[1] : pin2_q[0];

  always_ff @(posedge SYS_CLK_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      div_q   <= 5'h00;
      mclk_q  <= 1'b0;
      phase_q <= 1'b0;
      bclk_q  <= 1'b0;
      pos_q   <= LAST_POS;
    end else begin
      div_q <= tick ? 5'h00 : div_q + 5'h01;
      if (tick) begin
        mclk_q  <= ~mclk_q;
        phase_q <= ~phase_q;
      end
      if (tick && phase_q) begin
        bclk_q <= ~bclk_q;
      end
      if (b_rise) begin
        pos_q <= pos_nx;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // sync and data launched on bit clock rises
  always_ff @(posedge SYS_CLK_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      fs_q         <= 1'b0;
      dat_q        <= 1'b1;
      word_q       <= 8'h00;
      hold_q       <= 8'h00;
      full_q       <= 1'b0;
      TX_READY_OUT <= 1'b1;
    end else begin
      if (b_rise) begin
        fs_q <= fs_nx;
        if (load) begin
          word_q <= full_q ? hold_q : IDLE_CODE;
          dat_q  <= full_q ? hold_q[7] : IDLE_CODE[7];
        end else if (tx_idx < 8'h08) begin
          dat_q <= word_q[LAST_BIT - tx_idx[2:0]];
        end
      end
      if (load) begin
        full_q       <= 1'b0;
        TX_READY_OUT <= 1'b1;
      end
      if (take) begin
        hold_q       <= TX_DATA_IN;
        full_q       <= 1'b1;
        TX_READY_OUT <= 1'b0;
      end
    end
  end

  assign LINK.mclk          = mclk_q;
  assign LINK.tx_bit_clock  = bclk_q;
  assign LINK.rx_bit_clock  = bclk_q;
  assign LINK.link_clock    = bclk_q;
  assign LINK.tx_frame_sync = fs_q;
  assign LINK.rx_frame_sync = fs_q;
  assign LINK.link_sync     = fs_q;
  assign LINK.rx_serial_in  = dat_q;
  assign LINK.link_rx_data  = dat_q;

  //////////////////////////////////////////////////////////////////////////////
  // device's word captured on bit clock falls
  always_ff @(posedge SYS_CLK_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      pin1_q       <= 2'h3;
      pin2_q       <= 2'h3;
      rsh_q        <= 8'h00;
      RX_DATA_OUT  <= 8'h00;
      RX_VALID_OUT <= 1'b0;
    end else begin
      pin1_q       <= {LINK.link_tx_pin, LINK.tx_serial_pin};
      pin2_q       <= pin1_q;
      RX_VALID_OUT <= 1'b0;
      if (b_fall && rx_idx < 8'h08) begin
        rsh_q <= {rsh_q[6:0], pin_now};
        if (rx_idx == 8'h07) begin
          RX_DATA_OUT  <= {rsh_q[6:0], pin_now};
          RX_VALID_OUT <= 1'b1;
        end
      end
    end
  end
endmodule

// *** verification/pcm_codec_serial_port_test.sv ***
// pcm_codec_serial_port_test: both ends joined, words checked end to end and on the wire
`timescale 1ns/100ps
module pcm_codec_serial_port_test;
  import pcmsp_pkg::*;
  localparam int FLEN  = 24;
  localparam int FRAME = FLEN * 48;
  logic        sys_clk, arst_n, chan_b2, h_feed;
  pcmsp_mode_t mode;
  logic [7:0]  h_txd, d_txd, h_rxd, d_rxd, sh;
  logic        h_txv, d_txv, h_rdy, d_rdy, h_rxv, d_rxv, bq, oe_q;
  int          bad_count, checked;
  logic [7:0]  hq[$], dq[$], wq[$];
  bit          h_run, d_run, w_run;

  pcmsp_if i_pcmsp_if ();
  pcmsp_host #(.FRAME_LEN(FLEN)) i_pcmsp_host (.SYS_CLK_IN(sys_clk), .ARST_N_IN(arst_n),
    .MODE_IN(mode), .CHAN_B2_IN(chan_b2), .TX_DATA_IN(h_txd), .TX_VALID_IN(h_txv),
    .TX_READY_OUT(h_rdy), .RX_DATA_OUT(h_rxd), .RX_VALID_OUT(h_rxv), .LINK(i_pcmsp_if));
  pcmsp_dev i_pcmsp_dev (.SYS_CLK_IN(sys_clk), .ARST_N_IN(arst_n),
    .MODE_IN(mode), .CHAN_B2_IN(chan_b2), .TX_DATA_IN(d_txd), .TX_VALID_IN(d_txv),
    .TX_READY_OUT(d_rdy), .RX_DATA_OUT(d_rxd), .RX_VALID_OUT(d_rxv), .LINK(i_pcmsp_if));
  pcmsp_assertions i_pcmsp_assertions (.SYS_CLK_IN(sys_clk), .ARST_N_IN(arst_n),
    .MODE_IN(mode), .CHAN_B2_IN(chan_b2), .mclk(i_pcmsp_if.mclk),
    .tx_bit_clock(i_pcmsp_if.tx_bit_clock),
    .tx_frame_sync(i_pcmsp_if.tx_frame_sync), .tx_serial_oe(i_pcmsp_if.tx_serial_oe),
    .tx_serial_out(i_pcmsp_if.tx_serial_out), .link_sync(i_pcmsp_if.link_sync),
    .link_tx_oe(i_pcmsp_if.link_tx_oe), .link_tx_data(i_pcmsp_if.link_tx_data));

  wire oe_w  = (mode == MODE_LINK) ? i_pcmsp_if.link_tx_oe : i_pcmsp_if.tx_serial_oe;
  wire pin_w = (mode == MODE_LINK) ? i_pcmsp_if.link_tx_pin : i_pcmsp_if.tx_serial_pin;

  initial begin
    sys_clk = 1'b0;
    forever #10 sys_clk = ~sys_clk;
  end

  ////////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string what);
    checked++;
    if (seen !== exp) begin
      bad_count++;
      $display("BAD t=%0t %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask

  task automatic close_out;
    $display("comparisons %0d mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  // corner words first, then random; idle code never queued
  function automatic logic [7:0] pick(input int k);
    logic [7:0] w;
    w = (k == 0) ? 8'h80 : (k == 1) ? 8'h01 : (k == 2) ? 8'h00 : 8'($urandom);
    return (w == IDLE_CODE) ? 8'h5A : w;
  endfunction

  function automatic logic [7:0] next_exp(ref logic [7:0] q[$]);
    return q.size() ? q.pop_front() : IDLE_CODE;
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // host feeder and both receivers; idle words before first data are skipped
  always @(posedge sys_clk) begin
    if (arst_n && h_txv && h_rdy === 1'b1) begin
      hq.push_back(h_txd);
      h_txd <= pick(hq.size() + 3);
    end
    h_txv <= h_feed;
    if (arst_n && d_rxv === 1'b1 && (d_run || d_rxd !== IDLE_CODE)) begin
      d_run = 1'b1;
      check(d_rxd, next_exp(hq), "device rx");
    end
    if (arst_n && h_rxv === 1'b1 && (h_run || h_rxd !== IDLE_CODE)) begin
      h_run = 1'b1;
      check(h_rxd, next_exp(dq), "host rx");
    end
    if (bq && !i_pcmsp_if.tx_bit_clock && oe_w) sh = {sh[6:0], pin_w};
    if (arst_n && oe_q && !oe_w && (w_run || sh !== IDLE_CODE)) begin
      w_run = 1'b1;
      check(sh, next_exp(wq), "wire word");
    end
    bq   = i_pcmsp_if.tx_bit_clock;
    oe_q = oe_w;
  end

  ////////////////////////////////////////////////////////////////////////////////
  task automatic run_cfg(input pcmsp_mode_t m, input logic b2);
    int n;
    arst_n <= 1'b0;
    mode   <= m;
    chan_b2 <= b2;
    h_feed = 1'b0;
    d_txv  <= 1'b0;
    repeat (5) @(posedge sys_clk);
    hq.delete();
    dq.delete();
    wq.delete();
    {h_run, d_run, w_run} = 3'b000;
    arst_n <= 1'b1;
    repeat (2 * FRAME) @(posedge sys_clk);
    h_txd  <= pick(0);
    h_feed = 1'b1;
    d_txd  <= pick(0);
    d_txv  <= 1'b1;
    // fill the device fifo until it refuses
    for (n = 0; n < 40; n++) begin
      @(posedge sys_clk);
      if (d_rdy !== 1'b1) break;
      dq.push_back(d_txd);
      wq.push_back(d_txd);
      d_txd <= pick(dq.size());
    end
    d_txv <= 1'b0;
    check({7'h00, d_rdy}, 8'h00, "fifo refusal");
    check({7'h00, 1'(dq.size() >= FIFO_DEPTH)}, 8'h01, "fifo depth");
    repeat (14 * FRAME) @(posedge sys_clk);
    h_feed = 1'b0;
    check(8'(dq.size()), 8'h00, "device words lost");
    check({6'h00, d_run, h_run}, 8'h03, "no traffic");
    check({7'h00, 1'(hq.size() <= 2)}, 8'h01, "host words lost");
    $display("test mode %0d chan %0d done", m, b2);
  endtask

  initial begin
    {arst_n, chan_b2, h_feed, h_txv, d_txv, bq, oe_q} = '0;
    {h_txd, d_txd, sh} = '0;
    mode = MODE_LONG;
    bad_count = 0;
    checked = 0;
    void'($urandom(32'h1D39));
    run_cfg(MODE_LONG, 1'b0);
    run_cfg(MODE_SHORT, 1'b0);
    run_cfg(MODE_LINK, 1'b0);
    run_cfg(MODE_LINK, 1'b1);
    close_out();
  end
endmodule

// *** verification/pcmsp_assertions.sv ***
// pcmsp_assertions: wire-level checks of the serial pcm highway
`timescale 1ns/100ps
module pcmsp_assertions (
  // clock, reset and configuration
  input wire logic                   SYS_CLK_IN,
  input wire logic                   ARST_N_IN,
  input wire pcmsp_pkg::pcmsp_mode_t MODE_IN,
  input wire logic                   CHAN_B2_IN,
  // highway
  input wire logic                   mclk,
  input wire logic                   tx_bit_clock,
  input wire logic                   tx_frame_sync,
  input wire logic                   tx_serial_oe,
  input wire logic                   tx_serial_out,
  input wire logic                   link_sync,
  input wire logic                   link_tx_oe,
  input wire logic                   link_tx_data
);
  import pcmsp_pkg::*;
  default clocking cb @(posedge SYS_CLK_IN); endclocking
  default disable iff (!ARST_N_IN);
  logic       clk_q;
  logic [3:0] tcnt_q;
  logic [3:0] lcnt_q;
  logic [3:0] scnt_q;
  logic [7:0] pos_q;
  wire        fall_w = clk_q & ~tx_bit_clock;
  wire        rise_w = ~clk_q & tx_bit_clock;

  ////////////////////////////////////////////////////////////////////////////////
  // bits per window, falls under sync, rises since sync
  always_ff @(posedge SYS_CLK_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      {clk_q, tcnt_q, lcnt_q, scnt_q, pos_q} <= '0;
    end else begin
      clk_q  <= tx_bit_clock;
      tcnt_q <= tx_serial_oe ? tcnt_q + 4'(fall_w) : 4'h0;
      lcnt_q <= link_tx_oe ? lcnt_q + 4'(fall_w) : 4'h0;
      scnt_q <= tx_frame_sync ? scnt_q + 4'(fall_w) : 4'h0;
      pos_q  <= (link_sync && fall_w) ? 8'h00 : pos_q + 8'(rise_w);
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  oe_launch_rise_a: assert property ($rose(tx_serial_oe) |-> tx_bit_clock && !$past(tx_bit_clock, 5))
    else $error("transmit enable not after a bit clock rise");
  tx_bit_rise_a: assert property (tx_serial_oe && $past(tx_serial_oe) && $changed(tx_serial_out)
    |-> tx_bit_clock && !$past(tx_bit_clock, 5)) else $error("transmit bit moved off a rise");
  tx_release_fall_a: assert property ($fell(tx_serial_oe) |-> !tx_bit_clock && $past(tx_bit_clock, 5))
    else $error("transmit release not after a fall");
  tx_bit_count_a: assert property ($fell(tx_serial_oe) |-> tcnt_q == 4'h8)
    else $error("transmit window not eight bits");
  link_bit_rise_a: assert property (($rose(link_tx_oe) || link_tx_oe && $past(link_tx_oe)
    && $changed(link_tx_data)) |-> tx_bit_clock && !$past(tx_bit_clock, 5))
    else $error("link bit moved off a rise");
  link_release_a: assert property ($fell(link_tx_oe) |-> !tx_bit_clock && lcnt_q == 4'h8)
    else $error("link release wrong");
  link_slot_a: assert property ($rose(link_tx_oe) |-> pos_q == (CHAN_B2_IN ? 8'h0B : 8'h01))
    else $error("link slot start wrong");
  short_slot_a: assert property ($rose(tx_serial_oe) && MODE_IN == MODE_SHORT |-> pos_q == 8'h01)
    else $error("short frame start wrong");
  long_sync_hold_a: assert property ($fell(tx_frame_sync) && MODE_IN == MODE_LONG |-> scnt_q >= 4'h2)
    else $error("long sync dropped early");
  short_sync_one_a: assert property ($fell(tx_frame_sync) && MODE_IN == MODE_SHORT |-> scnt_q == 4'h1)
    else $error("short sync not one fall");
  oe_by_mode_a: assert property (!(tx_serial_oe && MODE_IN == MODE_LINK)
    && !(link_tx_oe && MODE_IN != MODE_LINK)) else $error("wrong pin enabled for mode");
  mclk_lock_a: assert property ($changed(tx_bit_clock) |-> $changed(mclk))
    else $error("bit clock not locked to master clock");
endmodule
